// [fcil_pkg.sv]
// constants, register map and types of the feeder control indication logic
package fcil_pkg;
  localparam int N_OBJ = 7;
  localparam int N_UNIT = 16;
  localparam int N_CHAN = 10;
  localparam int N_LATCH = 6;
  localparam int N_START = 3;
  localparam int N_MOD = 3;
  localparam int N_SHOT = 5;
  localparam int N_PROG = 14;
  localparam int N_TERM = 2 * N_OBJ + N_CHAN + 1;
  localparam int N_IRQ = 9;
  localparam int PULSE_CHAN = 3;
  localparam int CLOCK_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [15:0] CLOSE_PULSE_MS = 16'h0064;
  localparam logic [7:0] A_INPOL = 8'h00;
  localparam logic [7:0] A_LATCH_EN = 8'h04;
  localparam logic [7:0] A_LATCH_RST = 8'h08;
  localparam logic [7:0] A_CH_STATE = 8'h0C;
  localparam logic [7:0] A_AR_CFG = 8'h10;
  localparam logic [7:0] A_RECLAIM = 8'h14;
  localparam logic [7:0] A_DEAD0 = 8'h18;
  localparam logic [7:0] A_ENERGY = 8'h2C;
  localparam logic [7:0] A_SCALE = 8'h30;
  localparam logic [7:0] A_SCALED = 8'h34;
  localparam logic [7:0] A_IRQ_STAT = 8'h38;
  localparam logic [7:0] A_IRQ_MASK = 8'h3C;
  localparam logic [7:0] A_OBJ0 = 8'h40;
  localparam logic [7:0] A_AR_STAT = 8'h60;
  localparam logic [7:0] A_PROG0 = 8'h80;
  localparam int ARC_START = 0;
  localparam int ARC_SHOTS = 3;
  localparam int ARC_EN = 6;
  localparam int ARC_DUPLEX = 7;
  localparam int IRQ_AR_START = 0;
  localparam int IRQ_AR_CLOSE = 1;
  localparam int IRQ_AR_OK = 2;
  localparam int IRQ_AR_LOCK = 3;
  localparam int IRQ_PULSE = 4;
  localparam int IRQ_LATCH = 5;
  localparam int IRQ_MOD = 6;
  localparam logic [15:0] SCALE_RST = 16'h0100;
  typedef enum logic [2:0] {
    AR_IDLE = 3'b000,
    AR_DEAD = 3'b001,
    AR_CLOSE = 3'b010,
    AR_RECLAIM = 3'b011,
    AR_LOCKOUT = 3'b100
  } fcil_ar_state_t;
  typedef struct packed {
    logic orient;
    logic colour;
    logic en;
    logic [3:0] unit;
  } fcil_obj_cfg_t;
  typedef struct packed {
    logic [N_TERM-1:0] need_set;
    logic [N_TERM-1:0] need_clr;
  } fcil_prog_t;
endpackage : fcil_pkg

// [fcil_top.sv]
// feeder control indication, command and auto-reclose logic with apb registers
`timescale 1ns/1ps
`default_nettype none
module fcil_top
  import fcil_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // field pins
  input wire logic [N_OBJ-1:0] obj_open_in,
  input wire logic [N_OBJ-1:0] obj_closed_in,
  input wire logic [N_CHAN-1:0] chan_in,
  input wire logic btn_step,
  input wire logic btn_select,
  input wire logic key_local,
  input wire logic [N_START-1:0] prot_start,
  input wire logic [N_MOD-1:0] module_fault,
  // measurement from same-clock logic
  input wire logic [15:0] meas_raw,
  // lamps
  output logic [N_LATCH-1:0] chan_lamp,
  output logic [4*N_UNIT-1:0] unit_lamp,
  output logic [N_MOD-1:0] module_lamp,
  output logic ar_lamp,
  // commands
  output logic [5:0] cmd_open,
  output logic [5:0] cmd_close,
  output logic [1:0] cmd_signal,
  // interrupt
  output logic irq
);
  localparam int ASYNC_W = 2 * N_OBJ + N_CHAN + 3 + N_START + N_MOD;

  function automatic logic [2:0] clamp_shots(input logic [2:0] v);
    if (v == 3'h0) begin
      clamp_shots = 3'h1;
    end else if (v > 3'(N_SHOT)) begin
      clamp_shots = 3'(N_SHOT);
    end else begin
      clamp_shots = v;
    end
  endfunction : clamp_shots

  // input synchroniser
  logic [ASYNC_W-1:0] sync1;
  logic [ASYNC_W-1:0] sync2;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {module_fault, prot_start, key_local, btn_select, btn_step, chan_in, obj_closed_in, obj_open_in};
      sync2 <= sync1;
    end
  end
  wire logic [N_OBJ-1:0] obj_open_s = sync2[N_OBJ-1:0];
  wire logic [N_OBJ-1:0] obj_closed_s = sync2[2*N_OBJ-1:N_OBJ];
  wire logic [N_CHAN-1:0] chan_s = sync2[2*N_OBJ+N_CHAN-1:2*N_OBJ];
  wire logic step_s = sync2[2*N_OBJ+N_CHAN];
  wire logic select_s = sync2[2*N_OBJ+N_CHAN+1];
  wire logic local_s = sync2[2*N_OBJ+N_CHAN+2];
  wire logic [N_START-1:0] start_s = sync2[2*N_OBJ+N_CHAN+3+N_START-1:2*N_OBJ+N_CHAN+3];
  wire logic [N_MOD-1:0] fault_s = sync2[ASYNC_W-1:ASYNC_W-N_MOD];

  // registers
  logic [N_CHAN-1:0] inpol;
  logic [N_LATCH-1:0] latch_en;
  logic [7:0] ar_cfg;
  logic [15:0] reclaim_ms;
  logic [15:0] dead_ms [N_SHOT];
  logic [31:0] energy;
  logic [15:0] scale;
  logic [15:0] scaled;
  logic [N_IRQ-1:0] irq_stat;
  logic [N_IRQ-1:0] irq_mask;
  fcil_obj_cfg_t obj_cfg [N_OBJ];
  fcil_prog_t prog [N_PROG];
  logic [N_LATCH-1:0] latched;
  logic step_sel_d;
  logic [N_CHAN-1:0] active_d;
  logic [N_START-1:0] start_d;
  logic [N_MOD-1:0] fault_d;
  logic [1:0] cb_closed_d;
  logic last_closed;
  fcil_ar_state_t ar_state;
  logic [2:0] shot_idx;
  logic [15:0] ar_timer;
  logic [31:0] ms_count;

  // apb decode
  wire logic access = psel && penable;
  wire logic wr_fire = access && pready && pwrite;
  wire logic [5:0] word = paddr[7:2];
  wire logic is_dead = paddr >= A_DEAD0 && paddr < A_DEAD0 + 8'(4 * N_SHOT);
  wire logic is_obj = paddr >= A_OBJ0 && paddr < A_OBJ0 + 8'(4 * N_OBJ);
  wire logic is_prog = paddr >= A_PROG0 && paddr < A_PROG0 + 8'(8 * N_PROG);
  wire logic [2:0] dead_sel = 3'(word - A_DEAD0[7:2]);
  wire logic [2:0] obj_sel = 3'(word - A_OBJ0[7:2]);
  wire logic [3:0] prog_sel = 4'((word - A_PROG0[7:2]) >> 1);
  wire logic prog_hi = word[0];
  wire logic is_fixed = paddr == A_INPOL || paddr == A_LATCH_EN || paddr == A_LATCH_RST || paddr == A_CH_STATE
    || paddr == A_AR_CFG || paddr == A_RECLAIM || paddr == A_ENERGY || paddr == A_SCALE || paddr == A_SCALED
    || paddr == A_IRQ_STAT || paddr == A_IRQ_MASK || paddr == A_AR_STAT;
  wire logic mapped = paddr[1:0] == 2'h0 && (is_fixed || is_dead || is_obj || is_prog);
  wire logic wr_ok = wr_fire && mapped;
  wire logic remote_rst = wr_ok && paddr == A_LATCH_RST && pwdata[31:1] == 31'h0;

  // channel state
  wire logic [N_CHAN-1:0] active = chan_s ^ inpol;
  wire logic step_sel = step_s && select_s;
  wire logic local_rst = step_sel && !step_sel_d;
  wire logic latch_rst = local_rst || remote_rst;
  wire logic [N_LATCH-1:0] next_latched = latch_en & (active[N_LATCH-1:0] | (latched & {N_LATCH{!latch_rst}}));
  wire logic [N_LATCH-1:0] next_chan_lamp = active[N_LATCH-1:0] | (latch_en & latched & {N_LATCH{!latch_rst}});
  wire logic pulse = active[PULSE_CHAN] && !active_d[PULSE_CHAN];

  // object lamps, bit order per unit {green_h, green_v, red_h, red_v}
  wire logic [N_OBJ-1:0] obj_is_closed = obj_closed_s & ~obj_open_s;
  wire logic [N_OBJ-1:0] obj_is_open = obj_open_s & ~obj_closed_s;
  logic [4*N_UNIT-1:0] next_unit_lamp;
  always_comb begin
    logic red_on;
    logic green_on;
    red_on = 1'b0;
    green_on = 1'b0;
    next_unit_lamp = '0;
    for (int o = 0; o < N_OBJ; o++) begin
      red_on = obj_cfg[o].colour ? obj_is_open[o] : obj_is_closed[o];
      green_on = obj_cfg[o].colour ? obj_is_closed[o] : obj_is_open[o];
      if (obj_cfg[o].en) begin
        next_unit_lamp[4*obj_cfg[o].unit +: 4] = next_unit_lamp[4*obj_cfg[o].unit +: 4]
          | {green_on && obj_cfg[o].orient, green_on && !obj_cfg[o].orient,
             red_on && obj_cfg[o].orient, red_on && !obj_cfg[o].orient};
      end
    end
  end

  // output control program
  wire logic [N_TERM-1:0] term = {local_s, active, obj_closed_s, obj_open_s};
  logic [N_PROG-1:0] prog_out;
  always_comb begin
    for (int p = 0; p < N_PROG; p++) begin
      prog_out[p] = (prog[p].need_set != '0 || prog[p].need_clr != '0)
        && (term & prog[p].need_set) == prog[p].need_set && (term & prog[p].need_clr) == '0;
    end
  end

  // auto-reclose
  wire logic ms_tick = ms_count == 32'(MS_DIV - 1);
  wire logic [N_START-1:0] start_rise = start_s & ~start_d & ar_cfg[ARC_START +: N_START];
  wire logic ar_start = ar_cfg[ARC_EN] && start_rise != '0;
  wire logic [2:0] shots_max = clamp_shots(ar_cfg[ARC_SHOTS +: 3]);
  wire logic timer_done = ar_timer == 16'h0;
  wire logic more_shots = (shot_idx + 3'h1) < shots_max;
  wire logic [1:0] cb_closed = obj_closed_s[1:0];
  wire logic [1:0] cb_rise = cb_closed & ~cb_closed_d;
  wire logic next_last_closed = cb_rise[1] ? 1'b1 : (cb_rise[0] ? 1'b0 : last_closed);
  wire logic ar_closing = ar_state == AR_CLOSE;
  wire logic route_b = ar_cfg[ARC_DUPLEX] && last_closed;
  fcil_ar_state_t next_ar_state;
  logic [2:0] next_shot_idx;
  logic [15:0] next_ar_timer;
  logic ev_start;
  logic ev_close;
  logic ev_ok;
  logic ev_lock;
  always_comb begin
    next_ar_state = ar_state;
    next_shot_idx = shot_idx;
    next_ar_timer = (ms_tick && !timer_done) ? ar_timer - 16'h1 : ar_timer;
    ev_start = 1'b0;
    ev_close = 1'b0;
    ev_ok = 1'b0;
    ev_lock = 1'b0;
    unique case (ar_state)
      AR_IDLE: begin
        if (ar_start) begin
          next_ar_state = AR_DEAD;
          next_shot_idx = 3'h0;
          next_ar_timer = dead_ms[0];
          ev_start = 1'b1;
        end
      end
      AR_DEAD: begin
        if (timer_done) begin
          next_ar_state = AR_CLOSE;
          next_ar_timer = CLOSE_PULSE_MS;
          ev_close = 1'b1;
        end
      end
      AR_CLOSE: begin
        if (timer_done) begin
          next_ar_state = AR_RECLAIM;
          next_ar_timer = reclaim_ms;
        end
      end
      AR_RECLAIM: begin
        if (start_rise != '0 && more_shots) begin
          next_ar_state = AR_DEAD;
          next_shot_idx = shot_idx + 3'h1;
          next_ar_timer = dead_ms[shot_idx + 3'h1];
          ev_start = 1'b1;
        end else if (start_rise != '0) begin
          next_ar_state = AR_LOCKOUT;
          next_ar_timer = reclaim_ms;
          ev_lock = 1'b1;
        end else if (timer_done) begin
          next_ar_state = AR_IDLE;
          ev_ok = 1'b1;
        end
      end
      AR_LOCKOUT: begin
        if (timer_done) begin
          next_ar_state = AR_IDLE;
        end
      end
      default: begin
        next_ar_state = AR_IDLE;
      end
    endcase
  end

  // interrupt status, set wins over write-one clear
  wire logic [N_IRQ-1:0] irq_set = {fault_s & ~fault_d, |(next_latched & ~latched), pulse, ev_lock, ev_ok, ev_close, ev_start};
  wire logic [N_IRQ-1:0] irq_clr = (wr_ok && paddr == A_IRQ_STAT) ? pwdata[N_IRQ-1:0] : '0;
  wire logic [N_IRQ-1:0] next_irq_stat = irq_set | (irq_stat & ~irq_clr);

  // read mux
  wire logic [31:0] mult = meas_raw * scale;
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    if (is_dead) begin
      rdata = {16'h0, dead_ms[dead_sel]};
    end else if (is_obj) begin
      rdata = {25'h0, obj_cfg[obj_sel]};
    end else if (is_prog) begin
      rdata = {7'h0, prog_hi ? prog[prog_sel].need_clr : prog[prog_sel].need_set};
    end else begin
      unique case (paddr)
        A_INPOL: rdata = {22'h0, inpol};
        A_LATCH_EN: rdata = {26'h0, latch_en};
        A_CH_STATE: rdata = {10'h0, latched, 6'h0, active};
        A_AR_CFG: rdata = {24'h0, ar_cfg};
        A_RECLAIM: rdata = {16'h0, reclaim_ms};
        A_ENERGY: rdata = energy;
        A_SCALE: rdata = {16'h0, scale};
        A_SCALED: rdata = {16'h0, scaled};
        A_IRQ_STAT: rdata = {23'h0, irq_stat};
        A_IRQ_MASK: rdata = {23'h0, irq_mask};
        A_AR_STAT: rdata = {8'h0, ar_timer, last_closed, 1'h0, shot_idx, ar_state};
        default: rdata = 32'h0;
      endcase
    end
  end

  // apb handshake: one wait cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
      prdata <= (access && !pready && !pwrite && mapped) ? rdata : 32'h0;
    end
  end

  // software registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      inpol <= '0;
      latch_en <= '0;
      ar_cfg <= 8'h00;
      reclaim_ms <= 16'h0;
      scale <= SCALE_RST;
      irq_mask <= '0;
      for (int i = 0; i < N_SHOT; i++) begin
        dead_ms[i] <= 16'h0;
      end
      for (int i = 0; i < N_OBJ; i++) begin
        obj_cfg[i] <= '0;
      end
      for (int i = 0; i < N_PROG; i++) begin
        prog[i] <= '0;
      end
    end else if (wr_ok) begin
      if (paddr == A_INPOL) inpol <= pwdata[N_CHAN-1:0];
      if (paddr == A_LATCH_EN) latch_en <= pwdata[N_LATCH-1:0];
      if (paddr == A_AR_CFG) ar_cfg <= pwdata[7:0];
      if (paddr == A_RECLAIM) reclaim_ms <= pwdata[15:0];
      if (paddr == A_SCALE) scale <= pwdata[15:0];
      if (paddr == A_IRQ_MASK) irq_mask <= pwdata[N_IRQ-1:0];
      if (is_dead) dead_ms[dead_sel] <= pwdata[15:0];
      if (is_obj) obj_cfg[obj_sel] <= pwdata[6:0];
      if (is_prog && prog_hi) prog[prog_sel].need_clr <= pwdata[N_TERM-1:0];
      if (is_prog && !prog_hi) prog[prog_sel].need_set <= pwdata[N_TERM-1:0];
    end
  end

  // block state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      latched <= '0;
      step_sel_d <= 1'b0;
      active_d <= '0;
      start_d <= '0;
      fault_d <= '0;
      cb_closed_d <= 2'h0;
      last_closed <= 1'b0;
      energy <= 32'h0;
      irq_stat <= '0;
      ar_state <= AR_IDLE;
      shot_idx <= 3'h0;
      ar_timer <= 16'h0;
      ms_count <= 32'h0;
    end else begin
      latched <= next_latched;
      step_sel_d <= step_sel;
      active_d <= active;
      start_d <= start_s;
      fault_d <= fault_s;
      cb_closed_d <= cb_closed;
      last_closed <= next_last_closed;
      if (pulse) begin
        energy <= energy + 32'h1;
      end else if (wr_ok && paddr == A_ENERGY) begin
        energy <= 32'h0;
      end
      irq_stat <= next_irq_stat;
      ar_state <= next_ar_state;
      shot_idx <= next_shot_idx;
      ar_timer <= next_ar_timer;
      ms_count <= ms_tick ? 32'h0 : ms_count + 32'h1;
    end
  end

  // registered outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chan_lamp <= '0;
      unit_lamp <= '0;
      module_lamp <= '0;
      ar_lamp <= 1'b0;
      cmd_open <= 6'h0;
      cmd_close <= 6'h0;
      cmd_signal <= 2'h0;
      scaled <= 16'h0;
      irq <= 1'b0;
    end else begin
      chan_lamp <= next_chan_lamp;
      unit_lamp <= next_unit_lamp;
      module_lamp <= fault_s;
      ar_lamp <= next_ar_state == AR_DEAD;
      cmd_open <= prog_out[5:0];
      cmd_close <= prog_out[11:6] | {4'h0, ar_closing && route_b, ar_closing && !route_b};
      cmd_signal <= prog_out[13:12];
      scaled <= mult[23:8];
      irq <= (next_irq_stat & irq_mask) != '0;
    end
  end
endmodule : fcil_top
`default_nettype wire

// [fcil_assertions.sv]
// port-level checks of the feeder control block
`timescale 1ns/1ps
`default_nettype none
module fcil_assertions
  import fcil_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // field
  input wire logic [N_MOD-1:0] module_fault,
  input wire logic [N_MOD-1:0] module_lamp,
  input wire logic ar_lamp,
  input wire logic [5:0] cmd_close
);
  localparam int PW_MIN = 99 * MS_DIV;
  localparam int PW_MAX = 101 * MS_DIV + 2;
  int hi_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // cycles the reclose pulse has stood
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= (|cmd_close[1:0]) ? hi_cnt + 1 : 0;
    end
  end
  a_access_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not one cycle after access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_module_lamp: assert property ($stable(module_fault) [*5] |-> module_lamp == module_fault)
    else $error("module lamp not following condition");
  a_dead_close: assert property ($fell(ar_lamp) |-> ##[0:2] (cmd_close[1:0] != 2'h0))
    else $error("dead time ended without close");
  a_close_width: assert property ($fell(|cmd_close[1:0]) |-> hi_cnt >= PW_MIN && hi_cnt <= PW_MAX)
    else $error("close pulse width wrong");
  a_one_breaker: assert property (!(cmd_close[0] && cmd_close[1]))
    else $error("close sent to both breakers");
endmodule : fcil_assertions
`default_nettype wire

// [fcil_field.sv]
// breaker and protection model at the field side
`timescale 1ns/1ps
`default_nettype none
module fcil_field #(
  parameter int TRAVEL = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // commands from the block
  input wire logic [5:0] cmd_open,
  input wire logic [5:0] cmd_close,
  // bench control
  input wire logic [2:0] fault_req,
  input wire logic load,
  input wire logic [6:0] load_pos,
  // contacts and protection
  output logic [6:0] obj_open_in,
  output logic [6:0] obj_closed_in,
  output logic [2:0] prot_start
);
  logic [6:0] pos;
  logic [1:0] cl_q;
  int tmr;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pos <= 7'h00;
      cl_q <= 2'h0;
      tmr <= 0;
    end else begin
      cl_q <= cmd_close[1:0];
      tmr <= (tmr != 0) ? tmr - 1 : 0;
      if (load) begin
        pos <= load_pos;
      end else if ((|fault_req) && pos[1:0] != 2'h0) begin
        pos[1:0] <= 2'h0;
        tmr <= TRAVEL;
      end else if ((cmd_close[1:0] & ~cl_q) != 2'h0) begin
        pos[1:0] <= pos[1:0] | (cmd_close[1:0] & ~cl_q);
        tmr <= TRAVEL;
      end else if ((cmd_open[1:0] & pos[1:0]) != 2'h0) begin
        pos[1:0] <= pos[1:0] & ~cmd_open[1:0];
        tmr <= TRAVEL;
      end
    end
  end
  // breakers in travel show neither contact
  assign obj_closed_in = (tmr != 0) ? (pos & 7'h7C) : pos;
  assign obj_open_in = (tmr != 0) ? (~pos & 7'h7C) : ~pos;
  assign prot_start = fault_req;
endmodule : fcil_field
`default_nettype wire

// [fcil_top_tb.sv]
// testbench of the feeder control indication logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, x, g) begin checked++; if ((g) !== (x)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, x, g); end end
module fcil_top_tb
  import fcil_pkg::*;
;
  localparam int MS_DIV = 10;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic btn_step = 0, btn_select = 0, key_local = 0, load = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, ar_lamp, irq, e;
  logic [6:0] obj_open_in, obj_closed_in, load_pos = 0;
  logic [9:0] chan_in = 0;
  logic [2:0] fault_req = 0, module_fault = 0, prot_start, module_lamp;
  logic [15:0] meas_raw = 0;
  logic [5:0] chan_lamp, cmd_open, cmd_close;
  logic [63:0] unit_lamp;
  logic [1:0] cmd_signal;
  int errors = 0, checked = 0, cyc = 0, n;
  initial forever #50 clock = ~clock;
  fcil_top #(.MS_DIV(MS_DIV)) dut (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .obj_open_in, .obj_closed_in, .chan_in, .btn_step, .btn_select, .key_local,
    .prot_start, .module_fault, .meas_raw, .chan_lamp, .unit_lamp, .module_lamp, .ar_lamp, .cmd_open,
    .cmd_close, .cmd_signal, .irq);
  fcil_field field (.clock, .resetn, .cmd_open, .cmd_close, .fault_req, .load, .load_pos,
    .obj_open_in, .obj_closed_in, .prot_start);
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic pins(input int k);
    repeat (k) @(posedge clock);
  endtask : pins
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(nm, x, q & m)
  endtask : rdc
  task automatic set_obj(input logic [6:0] p);
    load_pos <= p;
    load <= 1'b1;
    pins(1);
    load <= 1'b0;
    pins(6);
  endtask : set_obj
  // one reclose shot: dead time length and breaker routing
  task automatic shot(input int d, input int b, input logic [2:0] f);
    fault_req <= f;
    n = 0;
    while (ar_lamp !== 1'b1) @(posedge clock);
    fault_req <= 3'h0;
    while (ar_lamp === 1'b1) begin
      @(posedge clock);
      n++;
    end
    `CHK("dead time", 1'b1, n >= (d - 1) * MS_DIV && n <= (d + 1) * MS_DIV + 2)
    pins(3);
    `CHK("close route", 2'b01 << b, cmd_close[1:0])
    while (cmd_close[b] === 1'b1) @(posedge clock);
  endtask : shot
  initial begin
    pins(6);
    resetn <= 1'b1;
    rdc("scale reset", A_SCALE, 32'hFFFF, 32'h0100);
    apb(1'b0, 8'h5C, 32'h0);
    `CHK("unmapped", 1'b1, e)
    apb(1'b0, 8'h01, 32'h0);
    `CHK("misaligned", 1'b1, e)
    wr(A_SCALE, 32'h200);
    meas_raw <= 16'h0123;
    pins(4);
    rdc("scaled", A_SCALED, 32'hFFFF, 32'h0246);
    wr(A_INPOL, 32'h002);
    pins(6);
    `CHK("low active", 6'h02, chan_lamp)
    chan_in <= 10'h001;
    pins(6);
    `CHK("lamp order", 6'h03, chan_lamp)
    rdc("active", A_CH_STATE, 32'h3FF, 32'h003);
    chan_in <= 10'h002;
    pins(6);
    `CHK("lamp follows", 6'h00, chan_lamp)
    wr(A_INPOL, 32'h0);
    chan_in <= 10'h000;
    wr(A_LATCH_EN, 32'h01);
    chan_in <= 10'h001;
    pins(6);
    chan_in <= 10'h000;
    pins(6);
    `CHK("latched", 6'h01, chan_lamp)
    rdc("latch irq", A_IRQ_STAT, 32'h20, 32'h20);
    btn_step <= 1'b1;
    pins(6);
    `CHK("step only", 6'h01, chan_lamp)
    btn_select <= 1'b1;
    pins(6);
    `CHK("local reset", 6'h00, chan_lamp)
    {btn_step, btn_select} <= 2'b00;
    for (int v = 0; v < 2; v++) begin
      chan_in <= 10'h001;
      pins(6);
      wr(A_LATCH_RST, v);
      chan_in <= 10'h000;
      pins(6);
      `CHK("active keeps", 6'h01, chan_lamp)
      wr(A_LATCH_RST, 32'h2);
      pins(2);
      `CHK("other value", 6'h01, chan_lamp)
      wr(A_LATCH_RST, v);
      pins(2);
      `CHK("remote reset", 6'h00, chan_lamp)
    end
    wr(A_IRQ_STAT, 32'hFFFFFFFF);
    wr(A_IRQ_MASK, 32'h10);
    for (int i = 0; i < 3; i++) begin
      chan_in <= 10'h008;
      pins(5);
      chan_in <= 10'h000;
      pins(5);
    end
    rdc("energy", A_ENERGY, 32'hFFFF, 32'h3);
    `CHK("irq up", 1'b1, irq)
    wr(A_IRQ_MASK, 32'h0);
    pins(2);
    `CHK("irq masked", 1'b0, irq)
    wr(A_IRQ_MASK, 32'h10);
    wr(A_IRQ_STAT, 32'h10);
    pins(2);
    `CHK("irq cleared", 1'b0, irq)
    wr(A_ENERGY, 32'h0);
    rdc("energy clear", A_ENERGY, 32'hFFFF, 32'h0);
    module_fault <= 3'b101;
    pins(6);
    `CHK("module lamp", 3'b101, module_lamp)
    rdc("module irq", A_IRQ_STAT, 32'h1C0, 32'h140);
    module_fault <= 3'b000;
    set_obj(7'h04);
    for (int i = 0; i < 4; i++) begin
      wr(A_OBJ0 + 8'h08, {25'h0, i[0], i[1], 1'b1, 4'h9});
      pins(3);
      `CHK("unit closed", 4'b0001 << i, unit_lamp[39:36])
    end
    `CHK("unused units", 60'h0, {unit_lamp[63:40], unit_lamp[35:0]})
    set_obj(7'h00);
    `CHK("unit open", 4'b0010, unit_lamp[39:36])
    set_obj(7'h04);
    wr(A_PROG0 + 8'h28, 32'h01000200);
    wr(A_PROG0 + 8'h64, 32'h00004000);
    for (int i = 0; i < 2; i++) begin
      key_local <= i[0];
      chan_in <= {9'h0, i[0]};
      pins(6);
      `CHK("open cmd", i[0], cmd_open[5])
      `CHK("signal cmd", ~i[0], cmd_signal[0])
    end
    wr(A_DEAD0, 32'h3);
    wr(A_DEAD0 + 8'h04, 32'h5);
    wr(A_RECLAIM, 32'd50);
    wr(A_IRQ_STAT, 32'hFFFFFFFF);
    set_obj(7'h01);
    wr(A_AR_CFG, 32'h57);
    shot(3, 0, 3'b001);
    pins(50);
    shot(5, 0, 3'b010);
    pins(50);
    fault_req <= 3'b100;
    pins(60);
    fault_req <= 3'b000;
    `CHK("no third shot", 1'b0, ar_lamp)
    rdc("lockout", A_IRQ_STAT, 32'hF, 32'hB);
    pins(600);
    set_obj(7'h01);
    set_obj(7'h03);
    wr(A_AR_CFG, 32'hC9);
    wr(A_IRQ_STAT, 32'hFFFFFFFF);
    shot(3, 1, 3'b001);
    pins(600);
    rdc("reclaim ok", A_IRQ_STAT, 32'hF, 32'h7);
    rdc("last closed", A_AR_STAT, 32'hFFFFFF, 32'h80);
    wr(A_AR_CFG, 32'hCE);
    fault_req <= 3'b001;
    pins(10);
    `CHK("start masked", 1'b0, ar_lamp)
    fault_req <= 3'b000;
    finish_test();
  end
endmodule : fcil_top_tb
bind fcil_top fcil_assertions #(.MS_DIV(MS_DIV)) u_chk (.clock, .resetn, .psel, .penable, .prdata,
  .pready, .pslverr, .module_fault, .module_lamp, .ar_lamp, .cmd_close);
`default_nettype wire
